/* rtl/pct_pkg.sv */
// Purpose: Shared constants and types of the PLL and clock tree controller
// Assumes: 200 MHz mclk, 8 MHz crystal, APB register access
// Notes: Register byte address is four times the register index
// Overview of operation
// - PLL rate is crystal rate times (R+1) divided by (N+1)
// - PLL produces clock ticks only while pll_on is set
// - Lock flag sets once the phase comparator sees steady lock
// - Comparator checks N-divided reference against R-divided feedback, emits up/down
// - Tree makes CPU, peripheral, USB, card and DC/DC clocks
// - Peripheral clock is the source for timer, watchdog, SPI, UART, ports
// - Alternate card clock divides the peripheral clock further
// - Every tree clock is gated by the power reduction mode
// - First prescaler reloads from the four-bit CPU clock reload field
// - Prescalers two to four reload from card, alternate and DC/DC fields
// - Crystal reference is treated as a fixed 8 MHz source
// - First prescaler divides with double speed clear, bypassed when set with crystal source selected
// - Third prescaler divides peripheral clock by 1, 2, 4 or 8
// - CPU clock source selects crystal oscillator or PLL clock
package pct_pkg;
  localparam int MCLK_MHZ = 200;
  localparam int XTAL_MHZ = 8;
  localparam int NCO_W = 16;
  // Crystal-rate step; the oscillator starts at this times (R+1)/(N+1) so acquisition is short
  localparam logic [15:0] NCO_START =
    16'(((1 << NCO_W) * XTAL_MHZ) / MCLK_MHZ);
  localparam logic [15:0] NCO_STEP = 16'h0040;
  localparam logic [15:0] NCO_MAX = 16'hfff0;
  localparam logic [4:0] LOCK_REFS = 5'h10;
  localparam logic [4:0] CNT5_ZERO = 5'h00;
  localparam logic [3:0] CNT4_ZERO = 4'h0;
  localparam logic [7:0] PS_ONE = 8'h01;
  localparam logic [7:0] PS_ZERO = 8'h00;
  localparam logic [31:0] WORD_ZERO = 32'h0000_0000;

  // Register indices
  localparam logic [7:0] IDX_PLL_CTRL = 8'h80;
  localparam logic [7:0] IDX_PLL_DIV = 8'h81;
  localparam logic [7:0] IDX_CPU_RELOAD = 8'h82;
  localparam logic [7:0] IDX_CLK_MODE = 8'h83;
  localparam logic [7:0] IDX_CARD_SEL = 8'h84;
  localparam logic [7:0] IDX_CARD_DIV = 8'h85;
  localparam logic [7:0] IDX_IRQ_STAT = 8'h86;
  localparam logic [7:0] IDX_IRQ_MASK = 8'h87;
  localparam logic [7:0] IDX_DCDC = 8'hbf;

  function automatic logic [11:0] reg_addr(input logic [7:0] idx);
    reg_addr = {2'b00, idx, 2'b00};
  endfunction : reg_addr

  localparam logic [11:0] ADDR_PLL_CTRL = reg_addr(IDX_PLL_CTRL);
  localparam logic [11:0] ADDR_PLL_DIV = reg_addr(IDX_PLL_DIV);
  localparam logic [11:0] ADDR_CPU_RELOAD = reg_addr(IDX_CPU_RELOAD);
  localparam logic [11:0] ADDR_CLK_MODE = reg_addr(IDX_CLK_MODE);
  localparam logic [11:0] ADDR_CARD_SEL = reg_addr(IDX_CARD_SEL);
  localparam logic [11:0] ADDR_CARD_DIV = reg_addr(IDX_CARD_DIV);
  localparam logic [11:0] ADDR_IRQ_STAT = reg_addr(IDX_IRQ_STAT);
  localparam logic [11:0] ADDR_IRQ_MASK = reg_addr(IDX_IRQ_MASK);
  localparam logic [11:0] ADDR_DCDC = reg_addr(IDX_DCDC);

  // Field positions and reset values
  localparam int CTRL_LOCK_BIT = 0;
  localparam int CTRL_ON_BIT = 1;
  localparam int DIV_N_LSB = 0;
  localparam int DIV_R_LSB = 4;
  localparam int DIV_W = 4;
  localparam int MODE_X2_BIT = 0;
  localparam int MODE_CKS_BIT = 1;
  localparam int ALT_LSB = 2;
  localparam int DCDC_LSB = 0;
  localparam int IRQ_LOCK_BIT = 0;
  localparam int IRQ_SLIP_BIT = 1;
  localparam logic [7:0] PLL_DIV_RST = 8'h00;
  localparam logic [3:0] CPU_RELOAD_RST = 4'hf;
  localparam logic [3:0] CPU_RELOAD_TOP = 4'hf;
  localparam logic [7:0] CARD_SEL_RST = 8'h00;
  localparam logic [5:0] CARD_DIV_RST = 6'h00;
  localparam logic [7:0] DCDC_RST = 8'h00;
  localparam logic [1:0] IRQ_RST = 2'h0;

  typedef enum logic [1:0] {
    PWR_RUN = 2'b00,
    PWR_IDLE = 2'b01,
    PWR_DOWN = 2'b11
  } pct_pwr_t;

  typedef enum logic [1:0] {
    PLL_OFF = 2'b00,
    PLL_ACQ = 2'b01,
    PLL_LOCK = 2'b11
  } pct_pll_st_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } pct_apb_req_t;

  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } pct_apb_rsp_t;

  typedef struct packed {
    logic cpu;
    logic periph;
    logic usb;
    logic card;
    logic alt_card;
    logic dcdc;
  } pct_clocks_t;
endpackage : pct_pkg

/* rtl/pct_prescaler.sv */
// Purpose: Reloadable prescaler, one output pulse per reload span of events
// Assumes: half is at least one
// Notes: Output pulse is one mclk late relative to its source event
`timescale 1ns/10ps
module pct_prescaler (
  // Clock and control
  input wire logic mclk,
  input wire logic srst,
  input wire logic ce,
  // Source events and reload
  input wire logic src_tick,
  input wire logic [7:0] half,
  // Divided events
  output logic div_tick
);
  import pct_pkg::*;

  logic [7:0] cnt;

  // Count source events and restart at the reload value
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      cnt <= PS_ZERO;
      div_tick <= 1'b0;
    end
    else if (ce)
    begin
      div_tick <= 1'b0;
      if (src_tick)
      begin
        if (cnt >= half - PS_ONE)
        begin
          cnt <= PS_ZERO;
          div_tick <= 1'b1;
        end
        else
        begin
          cnt <= cnt + PS_ONE;
        end
      end
    end
  end
endmodule : pct_prescaler

/* rtl/pct_clock_ctrl.sv */
// Purpose: PLL model with lock detect and gated clock tree, APB registers
// Assumes: crystal_input is asynchronous; pwr_mode comes from mclk logic
// Notes: Tree clocks are slow square waves built from mclk flip-flops
`timescale 1ns/10ps
module pct_clock_ctrl (
  // Clock, reset, enable
  input wire logic mclk,
  input wire logic srst,
  input wire logic ce,
  // APB slave
  input wire pct_pkg::pct_apb_req_t apb_req,
  output pct_pkg::pct_apb_rsp_t apb_rsp,
  // Crystal reference and power mode
  input wire logic crystal_input,
  input wire pct_pkg::pct_pwr_t pwr_mode,
  // Clock tree and interrupt
  output pct_pkg::pct_clocks_t clk_o,
  output logic irq
);
  import pct_pkg::*;

  // Saturating frequency step of the digital oscillator
  function automatic logic [15:0] nco_adjust(input logic [15:0] inc,
                                             input logic up,
                                             input logic dn);
    nco_adjust = inc;
    if (up && inc < NCO_MAX)
      nco_adjust = inc + NCO_STEP;
    else if (dn && inc > NCO_STEP)
      nco_adjust = inc - NCO_STEP;
  endfunction : nco_adjust

  // Oscillator preset from the divider ratio. The miss-detecting
  // comparator corrects slower as the error shrinks, so without a preset
  // lock would be flagged several percent off the target rate.
  function automatic logic [15:0] nco_preset(input logic [7:0] div);
    logic [20:0] scaled;
    scaled = 21'(NCO_START) * 21'(div[DIV_R_LSB +: DIV_W] + 5'h01);
    nco_preset = 16'(scaled / 21'(div[DIV_N_LSB +: DIV_W] + 5'h01));
  endfunction : nco_preset

  logic xs1, xs2, xs3;
  logic xtal_tick, xtal_fall;
  logic pll_on;
  logic [7:0] pll_div;
  logic [3:0] cpu_clock_reload;
  logic double_speed_bit, clock_source_select;
  logic [7:0] card_select_reg;
  logic [5:0] card_clock_divide;
  logic [7:0] dcdc_clock_reload;
  logic [1:0] irq_stat, irq_mask, irq_event;
  pct_pll_st_t pll_st, next_pll_st;
  logic pll_lock_flag;
  logic [3:0] ref_cnt, fb_cnt;
  logic ref_tick, fb_tick, vco_tick, fb_seen;
  logic pfd_up, pfd_dn;
  logic [15:0] nco_acc, nco_inc;
  logic [16:0] nco_sum;
  logic [4:0] clean_cnt;
  logic setup, wr_en;
  logic [31:0] next_rdata;
  logic next_err;
  logic x2_eff, pr1_src, pr1_tick, pr1_evt;
  logic card_tick, alt_tick, dcdc_tick;
  logic pr1_q, usb_q, card_q, alt_q, dcdc_q;
  logic [7:0] pr1_half, card_half, alt_half, dcdc_half;

  // Two-stage synchroniser; edges are taken from stage two onward only
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      xs1 <= 1'b0;
      xs2 <= 1'b0;
      xs3 <= 1'b0;
    end
    else if (ce)
    begin
      xs1 <= crystal_input;
      xs2 <= xs1;
      xs3 <= xs2;
    end
  end

  // Rising edges are the 8 MHz reference events
  assign xtal_tick = xs2 & ~xs3;
  assign xtal_fall = ~xs2 & xs3;

  // APB phases; pready is registered from setup so every access completes in its first access cycle
  assign setup = apb_req.psel & ~apb_req.penable;
  assign wr_en = ce & apb_req.psel & apb_req.penable & apb_req.pwrite &
                 apb_rsp.pready;

  // Software-written configuration registers
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      pll_on <= 1'b0;
      pll_div <= PLL_DIV_RST;
      cpu_clock_reload <= CPU_RELOAD_RST;
      double_speed_bit <= 1'b0;
      clock_source_select <= 1'b0;
      card_select_reg <= CARD_SEL_RST;
      card_clock_divide <= CARD_DIV_RST;
      dcdc_clock_reload <= DCDC_RST;
      irq_mask <= IRQ_RST;
    end
    else if (wr_en)
    begin
      case (apb_req.paddr)
        ADDR_PLL_CTRL: pll_on <= apb_req.pwdata[CTRL_ON_BIT];
        ADDR_PLL_DIV: pll_div <= apb_req.pwdata[7:0];
        ADDR_CPU_RELOAD: cpu_clock_reload <= apb_req.pwdata[3:0];
        ADDR_CLK_MODE:
        begin
          double_speed_bit <= apb_req.pwdata[MODE_X2_BIT];
          clock_source_select <= apb_req.pwdata[MODE_CKS_BIT];
        end
        ADDR_CARD_SEL: card_select_reg <= apb_req.pwdata[7:0];
        ADDR_CARD_DIV: card_clock_divide <= apb_req.pwdata[5:0];
        ADDR_IRQ_MASK: irq_mask <= apb_req.pwdata[1:0];
        ADDR_DCDC: dcdc_clock_reload <= apb_req.pwdata[7:0];
        default: ;
      endcase
    end
  end

  // Read mux; unmapped or misaligned addresses answer with pslverr
  always_comb
  begin
    next_rdata = WORD_ZERO;
    next_err = 1'b0;
    case (apb_req.paddr)
      ADDR_PLL_CTRL:
      begin
        next_rdata[CTRL_ON_BIT] = pll_on;
        next_rdata[CTRL_LOCK_BIT] = pll_lock_flag;
      end
      ADDR_PLL_DIV: next_rdata[7:0] = pll_div;
      ADDR_CPU_RELOAD: next_rdata[3:0] = cpu_clock_reload;
      ADDR_CLK_MODE:
      begin
        next_rdata[MODE_X2_BIT] = double_speed_bit;
        next_rdata[MODE_CKS_BIT] = clock_source_select;
      end
      ADDR_CARD_SEL: next_rdata[7:0] = card_select_reg;
      ADDR_CARD_DIV: next_rdata[5:0] = card_clock_divide;
      ADDR_IRQ_STAT: next_rdata[1:0] = irq_stat;
      ADDR_IRQ_MASK: next_rdata[1:0] = irq_mask;
      ADDR_DCDC: next_rdata[7:0] = dcdc_clock_reload;
      default: next_err = 1'b1;
    endcase
  end

  // Answer is sampled at setup and presented with pready in access
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      apb_rsp <= '0;
    end
    else if (ce)
    begin
      apb_rsp.pready <= setup;
      apb_rsp.pslverr <= setup & next_err;
      if (setup)
        apb_rsp.prdata <= next_rdata;
    end
  end

  // Reference divider: one tick every N+1 crystal edges
  assign ref_tick = pll_on & xtal_tick &
                    (ref_cnt == pll_div[DIV_N_LSB +: DIV_W]);
  // Feedback divider: one tick every R+1 oscillator ticks
  assign fb_tick = vco_tick &
                   (fb_cnt == pll_div[DIV_R_LSB +: DIV_W]);
  // Oscillator stands still while the PLL is disabled
  assign nco_sum = {1'b0, nco_acc} + {1'b0, nco_inc};
  assign vco_tick = pll_on & nco_sum[NCO_W];

  // Divider counters
  always_ff @(posedge mclk)
  begin
    if (srst || !pll_on)
    begin
      ref_cnt <= CNT4_ZERO;
      fb_cnt <= CNT4_ZERO;
    end
    else if (ce)
    begin
      if (ref_tick)
        ref_cnt <= CNT4_ZERO;
      else if (xtal_tick)
        ref_cnt <= ref_cnt + 4'h1;
      if (fb_tick)
        fb_cnt <= CNT4_ZERO;
      else if (vco_tick)
        fb_cnt <= fb_cnt + 4'h1;
    end
  end

  // Phase comparator: up when the reference finds no feedback edge,
  // down when a second feedback edge arrives before the reference
  always_ff @(posedge mclk)
  begin
    if (srst || !pll_on)
    begin
      fb_seen <= 1'b0;
      pfd_up <= 1'b0;
      pfd_dn <= 1'b0;
    end
    else if (ce)
    begin
      pfd_up <= ref_tick & ~fb_seen & ~fb_tick;
      pfd_dn <= fb_tick & fb_seen & ~ref_tick;
      if (ref_tick)
        fb_seen <= 1'b0;
      else if (fb_tick)
        fb_seen <= 1'b1;
    end
  end

  // Oscillator phase and rate; bang-bang steering trades jitter for size
  always_ff @(posedge mclk)
  begin
    if (srst || !pll_on)
    begin
      nco_acc <= '0;
      nco_inc <= nco_preset(pll_div);
    end
    else if (ce)
    begin
      nco_acc <= nco_sum[NCO_W-1:0];
      nco_inc <= nco_adjust(nco_inc, pfd_up, pfd_dn);
    end
  end

  // Lock detector counts reference periods free of correction pulses
  always_ff @(posedge mclk)
  begin
    if (srst || !pll_on)
      clean_cnt <= CNT5_ZERO;
    else if (ce)
    begin
      if (pfd_up || pfd_dn)
        clean_cnt <= CNT5_ZERO;
      else if (ref_tick && clean_cnt != LOCK_REFS)
        clean_cnt <= clean_cnt + 5'h01;
    end
  end

  // PLL state; disabling always drops straight to off
  always_comb
  begin
    next_pll_st = pll_st;
    unique case (pll_st)
      PLL_OFF:
        if (pll_on)
          next_pll_st = PLL_ACQ;
      PLL_ACQ:
        if (!pll_on)
          next_pll_st = PLL_OFF;
        else if (clean_cnt == LOCK_REFS)
          next_pll_st = PLL_LOCK;
      PLL_LOCK:
        if (!pll_on)
          next_pll_st = PLL_OFF;
      default: next_pll_st = PLL_OFF;
    endcase
  end

  always_ff @(posedge mclk)
  begin
    if (srst)
      pll_st <= PLL_OFF;
    else if (ce)
      pll_st <= next_pll_st;
  end

  assign pll_lock_flag = (pll_st == PLL_LOCK);

  // Events: lock gained, and a phase slip seen while locked
  assign irq_event[IRQ_LOCK_BIT] = (pll_st == PLL_ACQ) &&
                                   (next_pll_st == PLL_LOCK);
  assign irq_event[IRQ_SLIP_BIT] = pll_lock_flag & (pfd_up | pfd_dn);

  // Sticky status, write one to clear; a new event beats the clear
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      irq_stat <= IRQ_RST;
      irq <= 1'b0;
    end
    else if (ce)
    begin
      if (wr_en && apb_req.paddr == ADDR_IRQ_STAT)
        irq_stat <= (irq_stat & ~apb_req.pwdata[1:0]) | irq_event;
      else
        irq_stat <= irq_stat | irq_event;
      irq <= |(irq_stat & irq_mask);
    end
  end

  // PLL source is not allowed together with double speed; force it off
  assign x2_eff = double_speed_bit & ~clock_source_select;
  assign pr1_src = clock_source_select ? vco_tick : xtal_tick;
  // Half period of 16 minus reload gives 2*(16-reload) division
  assign pr1_half = {4'h0, CPU_RELOAD_TOP - cpu_clock_reload} + PS_ONE;
  // In bypass every crystal edge is a peripheral clock edge
  assign pr1_evt = x2_eff ? (xtal_tick | xtal_fall) : pr1_tick;
  assign card_half = {2'b00, card_clock_divide} + PS_ONE;
  assign alt_half = PS_ONE << card_select_reg[ALT_LSB +: 2];
  assign dcdc_half = {4'h0, dcdc_clock_reload[DCDC_LSB +: 4]} + PS_ONE;

  // First prescaler: CPU and peripheral clock
  pct_prescaler u_cpu_periph_prescaler (
    .mclk (mclk),
    .srst (srst),
    .ce (ce),
    .src_tick (pr1_src),
    .half (pr1_half),
    .div_tick (pr1_tick)
  );

  // Second prescaler: smart card clock from the PLL
  pct_prescaler u_card_prescaler (
    .mclk (mclk),
    .srst (srst),
    .ce (ce),
    .src_tick (vco_tick),
    .half (card_half),
    .div_tick (card_tick)
  );

  // Third prescaler: counts peripheral edges, ratio 1, 2, 4 or 8
  pct_prescaler u_alt_card_prescaler (
    .mclk (mclk),
    .srst (srst),
    .ce (ce),
    .src_tick (pr1_evt),
    .half (alt_half),
    .div_tick (alt_tick)
  );

  // Fourth prescaler: DC/DC clock, 50% duty from the crystal
  pct_prescaler u_dcdc_prescaler (
    .mclk (mclk),
    .srst (srst),
    .ce (ce),
    .src_tick (xtal_tick),
    .half (dcdc_half),
    .div_tick (dcdc_tick)
  );

  // Square waves toggle on each divided event
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      pr1_q <= 1'b0;
      usb_q <= 1'b0;
      card_q <= 1'b0;
      alt_q <= 1'b0;
      dcdc_q <= 1'b0;
    end
    else if (ce)
    begin
      if (pr1_tick)
        pr1_q <= ~pr1_q;
      if (vco_tick)
        usb_q <= ~usb_q;
      if (card_tick)
        card_q <= ~card_q;
      if (alt_tick)
        alt_q <= ~alt_q;
      if (dcdc_tick)
        dcdc_q <= ~dcdc_q;
    end
  end

  // Gating: idle stops the CPU only, power down stops every clock.
  // Periph is the single source that timers, watchdog, SPI, UART and
  // port sampling divide further.
  always_ff @(posedge mclk)
  begin
    if (srst)
      clk_o <= '0;
    else if (ce)
    begin
      clk_o.cpu <= (pwr_mode == PWR_RUN) & (x2_eff ? xs2 : pr1_q);
      clk_o.periph <= (pwr_mode != PWR_DOWN) &
                      (x2_eff ? xs2 : pr1_q);
      clk_o.usb <= (pwr_mode != PWR_DOWN) & usb_q;
      clk_o.card <= (pwr_mode != PWR_DOWN) & card_q;
      clk_o.alt_card <= (pwr_mode != PWR_DOWN) & alt_q;
      clk_o.dcdc <= (pwr_mode != PWR_DOWN) & dcdc_q;
    end
  end

  // Checks
  a_pll_off_quiet: assert property (@(posedge mclk) disable iff (srst)
    (ce && !pll_on) |=> nco_acc == '0 && ref_cnt == CNT4_ZERO)
    else $error("PLL ticks while disabled");

  a_lock_drop: assert property (@(posedge mclk) disable iff (srst)
    (ce && !pll_on) |=> !pll_lock_flag)
    else $error("Lock flag survives disable");

  a_lock_needs_clean: assert property (@(posedge mclk) disable iff (srst)
    (ce && pll_st == PLL_ACQ && !pll_lock_flag) ##1 pll_lock_flag
    |-> $past(clean_cnt) == LOCK_REFS)
    else $error("Lock set without clean reference periods");

  a_pfd_up_cause: assert property (@(posedge mclk) disable iff (srst)
    (ce && pll_on && ref_tick && !fb_seen && !fb_tick) |=> pfd_up)
    else $error("Missing up pulse");

  a_pfd_exclusive: assert property (@(posedge mclk) disable iff (srst)
    !(pfd_up && pfd_dn))
    else $error("Up and down together");

  a_ref_restart: assert property (@(posedge mclk) disable iff (srst)
    (ce && ref_tick) |=> ref_cnt == CNT4_ZERO)
    else $error("Reference divider did not restart");

  a_gate_down: assert property (@(posedge mclk) disable iff (srst)
    (ce && pwr_mode == PWR_DOWN) |=> !clk_o.periph && !clk_o.usb &&
    !clk_o.card && !clk_o.dcdc && !clk_o.cpu)
    else $error("Clock running in power down");

  a_x2_bypass: assert property (@(posedge mclk) disable iff (srst)
    (ce && x2_eff && pwr_mode == PWR_RUN) |=> clk_o.cpu == $past(xs2))
    else $error("Double speed did not bypass prescaler");

  a_apb_ready: assert property (@(posedge mclk) disable iff (srst)
    (ce && setup) |=> apb_rsp.pready)
    else $error("No ready after setup");
endmodule : pct_clock_ctrl

/* verif/pct_fw_model.sv */
// Purpose: Firmware model, APB master that programs the clock controller
// Assumes: one transfer at a time; the slave answers with pready
// Notes: A lost answer is left to the bench watchdog
`timescale 1ns/10ps
module pct_fw_model (
  // Clock
  input wire logic mclk,
  // APB master side
  output pct_pkg::pct_apb_req_t apb_req,
  input wire pct_pkg::pct_apb_rsp_t apb_rsp
);
  import pct_pkg::*;

  // Bus idle from time zero
  initial apb_req = '0;

  // One APB transfer; request held until pready is seen high
  task automatic xfer(input logic w, input logic [11:0] a,
                      input logic [31:0] wd, output logic [31:0] rd,
                      output logic err);
    @(posedge mclk);
    apb_req <= '{1'b1, 1'b0, w, a, wd};
    @(posedge mclk);
    apb_req.penable <= 1'b1;
    do
    begin
      @(posedge mclk);
    end
    while (apb_rsp.pready !== 1'b1);
    rd = apb_rsp.prdata;
    err = apb_rsp.pslverr;
    apb_req.psel <= 1'b0;
    apb_req.penable <= 1'b0;
  endtask : xfer

  // Dividers first, then enable, then poll the lock flag (bounded)
  task automatic bring_up(input logic [7:0] div, output logic ok);
    logic [31:0] d;
    logic e;
    int k;
    xfer(1'b1, ADDR_PLL_DIV, {24'h000000, div}, d, e);
    xfer(1'b1, ADDR_PLL_CTRL, 32'h00000002, d, e);
    ok = 1'b0;
    for (k = 0; k < 15000 && !ok; k++)
    begin
      xfer(1'b0, ADDR_PLL_CTRL, 32'h00000000, d, e);
      ok = (d[CTRL_LOCK_BIT] === 1'b1);
    end
  endtask : bring_up
endmodule : pct_fw_model

/* verif/pll_clock_tree_controller_tb.sv */
// Purpose: Self-checking bench of the PLL and clock tree controller
// Assumes: 200 MHz mclk, 8 MHz crystal, firmware model as APB master
// Notes: Tree clocks are judged by rising edges counted over 2000 cycles
`timescale 1ns/10ps
module pll_clock_tree_controller_tb;
  import pct_pkg::*;
  localparam int CPU = 5;
  localparam int PER = 4;
  localparam int USB = 3;
  localparam int CARD = 2;
  localparam int ALT = 1;
  localparam int DCDC = 0;
  logic mclk;
  logic srst;
  logic crystal_input;
  pct_pwr_t pwr_mode;
  pct_apb_req_t apb_req;
  pct_apb_rsp_t apb_rsp;
  pct_clocks_t clk_o;
  logic irq;
  int errors;
  int n_checks;
  int cnt [6];
  logic [31:0] rd;
  logic err;
  logic ok;

  // 200 MHz clock
  initial mclk = 1'b0;
  always #2.5 mclk = ~mclk;

  // 8 MHz crystal; the offset keeps its edges away from mclk edges
  initial
  begin
    crystal_input = 1'b0;
    #1.1;
    forever #62.5 crystal_input = ~crystal_input;
  end

  pct_clock_ctrl u_dut (.mclk(mclk), .srst(srst), .ce(1'b1),
    .apb_req(apb_req), .apb_rsp(apb_rsp), .crystal_input(crystal_input),
    .pwr_mode(pwr_mode), .clk_o(clk_o), .irq(irq));
  pct_fw_model u_fw (.mclk(mclk), .apb_req(apb_req), .apb_rsp(apb_rsp));

  // Exact compare of design values
  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    n_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // Compare of a counted rate with a small tolerance
  task automatic near(input string what, input int exp, input int got);
    n_checks++;
    if (got < exp - exp / 100 - 1 || got > exp + exp / 100 + 1)
    begin
      errors++;
      $display("mismatch %s expected %0d seen %0d", what, exp, got);
    end
  endtask : near

  task automatic rd_chk(input string what, input logic [11:0] a,
                        input logic [31:0] exp);
    u_fw.xfer(1'b0, a, 32'h00000000, rd, err);
    chk(what, exp, rd);
  endtask : rd_chk

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    u_fw.xfer(1'b1, a, d, rd, err);
  endtask : wr

  // Count rising edges of every tree clock over n cycles
  task automatic measure(input int n);
    logic [5:0] prev;
    logic [5:0] cur;
    cnt = '{default: 0};
    prev = clk_o;
    for (int i = 0; i < n; i++)
    begin
      @(posedge mclk);
      #1;
      cur = clk_o;
      for (int b = 0; b < 6; b++)
        if (cur[b] === 1'b1 && prev[b] !== 1'b1) cnt[b]++;
      prev = cur;
    end
  endtask : measure

  task automatic report_and_stop;
    if (errors == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : report_and_stop

  // Watchdog; a lost APB answer would otherwise hang the run
  initial
  begin
    repeat (95000) @(posedge mclk);
    errors++;
    report_and_stop();
  end

  // Main sequence
  initial
  begin
    errors = 0;
    n_checks = 0;
    srst = 1'b1;
    pwr_mode = PWR_RUN;
    repeat (16) @(posedge mclk);
    srst <= 1'b0;
    rd_chk("ctrl", ADDR_PLL_CTRL, 32'h00000000);
    rd_chk("div", ADDR_PLL_DIV, 32'h00000000);
    rd_chk("reload", ADDR_CPU_RELOAD, 32'h0000000f);
    rd_chk("mode", ADDR_CLK_MODE, 32'h00000000);
    rd_chk("card_sel", ADDR_CARD_SEL, 32'h00000000);
    rd_chk("card_div", ADDR_CARD_DIV, 32'h00000000);
    rd_chk("dcdc", ADDR_DCDC, 32'h00000000);
    rd_chk("stat", ADDR_IRQ_STAT, 32'h00000000);
    rd_chk("mask", ADDR_IRQ_MASK, 32'h00000000);
    rd_chk("unmapped", 12'h004, 32'h00000000);
    chk("slverr", 32'h00000001, {31'h0, err});
    wr(ADDR_PLL_CTRL, 32'h00000001);
    rd_chk("lock_ro", ADDR_PLL_CTRL, 32'h00000000);
    // Crystal-fed tree: 4 MHz cpu and dcdc, no PLL clock while off
    measure(2000);
    near("cpu", 40, cnt[CPU]);
    near("periph", 40, cnt[PER]);
    near("dcdc", 40, cnt[DCDC]);
    near("alt0", 40, cnt[ALT]);
    chk("usb_off", 32'h00000000, 32'(cnt[USB]));
    wr(ADDR_CPU_RELOAD, 32'h0000000e);
    wr(ADDR_DCDC, 32'h000000f1);
    rd_chk("dcdc_rb", ADDR_DCDC, 32'h000000f1);
    measure(2000);
    near("cpu_e", 20, cnt[CPU]);
    near("dcdc_1", 20, cnt[DCDC]);
    wr(ADDR_CLK_MODE, 32'h00000001);
    measure(2000);
    near("cpu_x2", 80, cnt[CPU]);
    wr(ADDR_CLK_MODE, 32'h00000000);
    wr(ADDR_CPU_RELOAD, 32'h0000000f);
    // Alternate card divide by 2, 4 and 8
    for (int k = 1; k < 4; k++)
    begin
      wr(ADDR_CARD_SEL, 32'(k << ALT_LSB));
      measure(2000);
      near("alt", 40 >> k, cnt[ALT]);
    end
    // Power reduction gating
    @(posedge mclk);
    pwr_mode <= PWR_IDLE;
    measure(2000);
    chk("idle_cpu", 32'h00000000, 32'(cnt[CPU]));
    near("idle_per", 40, cnt[PER]);
    @(posedge mclk);
    pwr_mode <= PWR_DOWN;
    measure(2000);
    chk("down", 32'h00000000, 32'(cnt[CPU] + cnt[PER] + cnt[ALT] +
        cnt[CARD] + cnt[DCDC]));
    @(posedge mclk);
    pwr_mode <= PWR_RUN;
    // PLL at 96 MHz; lock event masked, then raised, then cleared
    wr(ADDR_CARD_DIV, 32'h00000001);
    u_fw.bring_up(8'hb0, ok);
    chk("locked", 32'h00000001, {31'h0, ok});
    u_fw.xfer(1'b0, ADDR_IRQ_STAT, 32'h00000000, rd, err);
    chk("stat_lock", 32'h00000001, rd & 32'h00000001);
    chk("irq_masked", 32'h00000000, {31'h0, irq});
    wr(ADDR_IRQ_MASK, 32'h00000001);
    repeat (2) @(posedge mclk);
    #1;
    chk("irq_on", 32'h00000001, {31'h0, irq});
    wr(ADDR_IRQ_STAT, 32'h00000001);
    repeat (2) @(posedge mclk);
    #1;
    chk("irq_clr", 32'h00000000, {31'h0, irq});
    wr(ADDR_CLK_MODE, 32'h00000002);
    measure(2000);
    near("usb", 480, cnt[USB]);
    near("card", 240, cnt[CARD]);
    near("cpu_pll", 480, cnt[CPU]);
    // Disable drops lock and stops the PLL clocks
    wr(ADDR_PLL_CTRL, 32'h00000000);
    rd_chk("unlock", ADDR_PLL_CTRL, 32'h00000000);
    measure(2000);
    chk("usb_stop", 32'h00000000, 32'(cnt[USB]));
    report_and_stop();
  end
endmodule : pll_clock_tree_controller_tb
